// ---- core/load_jam_stage.sv ----
// Purpose: Load jam overcurrent stage supervision with register access
// Assumes: Currents in hundredths of nominal, one 5 ms program cycle tick
// Notes: Timing counts in program cycles; registers over Avalon-MM
//
// Notes on behaviour
// - Condition shows one of normal, started, tripped or blocked.
// - Expected operating time reported in 5 ms steps.
// - Remaining time to trip reported signed, 5 ms steps.
// - Ratio of highest phase current to pick-up, hundredths.
// - Block input sampled at program cycle start before pick-up check.
// - Pick-up without block raises start and starts timing.
// - Pick-up with block raises blocked and does no timing.
// - Block during start clears start and runs release timing.
// - Six events: on and off for start, trip and blocked.
// - Per-event setting picks which events reach the buffer.
// - Each event carries a stamp taken at the status change.
// - Separate cumulative counters for start, trip and blocked.
// - Latest twelve stamped fault records are kept.
// - Records written only on start, trip or blocked assertion.
// - Record holds stamp, event, type, currents, remaining, group.
// - Trip follows a fixed configured delay after start.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
module load_jam_stage
   import jam_pkg::*;
#(
   parameter int TICK_CYCLES = PROG_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire avs_req_type avs_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire phase_cur_type cur_i,
   input wire logic block_i,
   input wire logic [31:0] timestamp_i,
   input wire logic [2:0] setting_group_i,
   output logic start_o,
   output logic trip_o,
   output logic blocked_o,
   output event_type event_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic blk1;
      logic blk2;
      logic [31:0] pre;
      cond_type cond;
      logic [19:0] timer;
      logic [19:0] rel;
      logic [HIST_N-1:0][15:0] hist;
      logic [5:0] hptr;
      logic [4:0] dcnt;
      logic [22:0] dnum;
      logic [15:0] drem;
      logic [22:0] dquo;
      logic [19:0] ratio;
      logic [5:0] pend;
      logic [31:0] ev_ts;
      event_type ev;
      logic [31:0] cnt_start;
      logic [31:0] cnt_trip;
      logic [31:0] cnt_block;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic enable;
      logic [15:0] pickup;
      logic [19:0] delay;
      logic [19:0] release_t;
      logic [5:0] ev_fwd;
      logic [3:0] rec_sel;
      logic [REC_N-1:0][$bits(record_type)-1:0] rec;
      logic [3:0] wptr;
      logic [3:0] rcount;
      logic ack;
      logic [31:0] rdata;
   } state_type;

   state_type s_ff;
   state_type nxt_s;
   logic tick;
   logic [15:0] imax;
   logic pickup_hit;
   logic [20:0] remain;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [5:0] hist_back(input logic [5:0] p,
                                            input int back);
      int v;
      v = int'(p) - 1 - back;
      if (v < 0) begin
         v = v + HIST_N;
      end
      return v[5:0];
   endfunction

   function automatic logic [3:0] rec_index(input logic [3:0] p,
                                            input logic [3:0] age);
      int v;
      v = int'(p) - 1 - int'(age);
      if (v < 0) begin
         v = v + REC_N;
      end
      return v[3:0];
   endfunction

   assign imax = (cur_i.l1 >= cur_i.l2) ?
                 ((cur_i.l1 >= cur_i.l3) ? cur_i.l1 : cur_i.l3) :
                 ((cur_i.l2 >= cur_i.l3) ? cur_i.l2 : cur_i.l3);
   assign pickup_hit = s_ff.enable && (imax >= s_ff.pickup);
   assign tick = (s_ff.pre == 32'h0);
   // Signed remaining time, zero at trip since timer stops at delay; negative only if delay is written below timer
   assign remain = 21'(signed'({1'b0, s_ff.delay})
                   - signed'({1'b0, s_ff.timer}));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic blk;
      logic start_n;
      logic trip_n;
      logic blocked_n;
      logic [5:0] evs;
      logic found;
      logic [31:0] rd;
      record_type r;
      record_type rr;
      logic [16:0] trial;
      blk = 1'b0;
      start_n = 1'b0;
      trip_n = 1'b0;
      blocked_n = 1'b0;
      evs = 6'h0;
      found = 1'b0;
      rd = 32'h0;
      r = '0;
      rr = '0;
      trial = 17'h0;
      nxt_s = s_ff;
      nxt_s.blk1 = block_i;
      nxt_s.blk2 = s_ff.blk1;
      nxt_s.ev.valid = 1'b0;
      nxt_s.pre = tick ? 32'(TICK_CYCLES - 1) : s_ff.pre - 32'h1;
      // Ratio by serial division so no wide divider sits in one cycle
      if (s_ff.dcnt != 5'h0) begin
         trial = {s_ff.drem, s_ff.dnum[22]};
         nxt_s.dnum = {s_ff.dnum[21:0], 1'b0};
         if (trial >= {1'b0, s_ff.pickup}) begin
            nxt_s.drem = 16'(trial - {1'b0, s_ff.pickup});
            nxt_s.dquo = {s_ff.dquo[21:0], 1'b1};
         end else begin
            nxt_s.drem = trial[15:0];
            nxt_s.dquo = {s_ff.dquo[21:0], 1'b0};
         end
         nxt_s.dcnt = s_ff.dcnt - 5'h1;
         if (s_ff.dcnt == 5'h1) begin
            nxt_s.ratio = (nxt_s.dquo > 23'hfffff) ? 20'hfffff :
                          nxt_s.dquo[19:0];
         end
      end
      if (tick) begin
         // Block level taken here, ahead of the pick-up decision
         blk = s_ff.blk2;
         nxt_s.hist[s_ff.hptr] = imax;
         nxt_s.hptr = (s_ff.hptr == 6'(HIST_N - 1)) ? 6'h0 :
                      s_ff.hptr + 6'h1;
         nxt_s.dnum = 23'(imax * 23'd100);
         nxt_s.drem = 16'h0;
         nxt_s.dquo = 23'h0;
         nxt_s.dcnt = 5'(DIV_STEPS);
         unique case (s_ff.cond)
            COND_NORMAL: begin
               if (s_ff.rel != 20'h0) begin
                  nxt_s.rel = s_ff.rel - 20'h1;
               end else begin
                  nxt_s.timer = 20'h0;
               end
               if (pickup_hit && blk) begin
                  nxt_s.cond = COND_BLOCKED;
               end else if (pickup_hit) begin
                  nxt_s.cond = COND_START;
                  nxt_s.rel = 20'h0;
                  if (s_ff.rel == 20'h0) begin
                     nxt_s.timer = 20'h0;
                  end
               end
            end
            COND_START: begin
               if (blk || !pickup_hit) begin
                  // Block acts like a drop-out of pick-up
                  nxt_s.rel = s_ff.release_t;
                  nxt_s.cond = (blk && pickup_hit) ? COND_BLOCKED :
                               COND_NORMAL;
               end else if (s_ff.timer + 20'h1 >= s_ff.delay) begin
                  nxt_s.timer = s_ff.delay;
                  nxt_s.cond = COND_TRIP;
               end else begin
                  nxt_s.timer = s_ff.timer + 20'h1;
               end
            end
            COND_TRIP: begin
               if (!pickup_hit) begin
                  nxt_s.cond = COND_NORMAL;
                  nxt_s.timer = 20'h0;
               end
            end
            COND_BLOCKED: begin
               if (!pickup_hit || !blk) begin
                  nxt_s.cond = COND_NORMAL;
               end
               if (s_ff.rel != 20'h0) begin
                  nxt_s.rel = s_ff.rel - 20'h1;
               end else begin
                  nxt_s.timer = 20'h0;
               end
            end
            default: begin
               nxt_s.cond = COND_NORMAL;
            end
         endcase
         start_n = (nxt_s.cond == COND_START) || (nxt_s.cond == COND_TRIP);
         trip_n = (nxt_s.cond == COND_TRIP);
         blocked_n = (nxt_s.cond == COND_BLOCKED);
         // Six event kinds from output edges
         evs = {!blocked_n && blocked_o, blocked_n && !blocked_o,
                !trip_n && trip_o, trip_n && !trip_o,
                !start_n && start_o, start_n && !start_o};
         nxt_s.pend = s_ff.pend | evs;
         if (evs != 6'h0) begin
            nxt_s.ev_ts = timestamp_i;
         end
         if (evs[EV_START_ON]) nxt_s.cnt_start = s_ff.cnt_start + 32'h1;
         if (evs[EV_TRIP_ON]) nxt_s.cnt_trip = s_ff.cnt_trip + 32'h1;
         if (evs[EV_BLOCK_ON]) nxt_s.cnt_block = s_ff.cnt_block + 32'h1;
         // At most one assertion per tick, so one record slot suffices
         if (evs[EV_START_ON] || evs[EV_TRIP_ON] || evs[EV_BLOCK_ON]) begin
            r.stamp = timestamp_i;
            r.code = evs[EV_TRIP_ON] ? EV_TRIP_ON :
                     evs[EV_BLOCK_ON] ? EV_BLOCK_ON : EV_START_ON;
            r.ftype = {cur_i.l3 >= s_ff.pickup, cur_i.l2 >= s_ff.pickup,
                       cur_i.l1 >= s_ff.pickup};
            r.pre_trig = s_ff.hist[hist_back(s_ff.hptr, PRE_TRIG_TICKS - 1)];
            r.fault = imax;
            r.pre_fault = s_ff.hist[hist_back(s_ff.hptr,
                                              PRE_FAULT_TICKS - 1)];
            r.remain = 21'({1'b0, s_ff.delay} - {1'b0, nxt_s.timer});
            r.group = setting_group_i;
            nxt_s.rec[s_ff.wptr] = r;
            // Ring pointer wraps over the oldest slot
            nxt_s.wptr = (s_ff.wptr == 4'(REC_N - 1)) ? 4'h0 :
                         s_ff.wptr + 4'h1;
            if (s_ff.rcount != 4'(REC_N)) begin
               nxt_s.rcount = s_ff.rcount + 4'h1;
            end
         end
      end else begin
         // Drain one pending event per cycle; ticks are far apart
         for (int i = 0; i < 6; i++) begin
            if (!found && s_ff.pend[i]) begin
               found = 1'b1;
               nxt_s.pend[i] = 1'b0;
               nxt_s.ev.valid = s_ff.ev_fwd[i];
               nxt_s.ev.code = ev_code_type'(3'(i));
               nxt_s.ev.stamp = s_ff.ev_ts;
            end
         end
      end
      // ----------------------------------------------------------------
      // Register bus: one wait cycle, then answer
      // ----------------------------------------------------------------
      nxt_s.ack = (avs_i.read || avs_i.write) && !s_ff.ack;
      rr = s_ff.rec[rec_index(s_ff.wptr, s_ff.rec_sel)];
      if (s_ff.rec_sel >= s_ff.rcount) begin
         rr = '0;
      end
      unique case (avs_i.address)
         OFS_CTRL: rd = {31'h0, s_ff.enable};
         OFS_PICKUP: rd = {16'h0, s_ff.pickup};
         OFS_DELAY: rd = {12'h0, s_ff.delay};
         OFS_RELEASE: rd = {12'h0, s_ff.release_t};
         OFS_EV_FWD: rd = {26'h0, s_ff.ev_fwd};
         OFS_STATUS: rd = {8'h0, s_ff.ratio, s_ff.cond};
         OFS_EXP_TIME: rd = {12'h0, s_ff.delay};
         OFS_REMAIN: rd = {{11{remain[20]}}, remain};
         OFS_CNT_START: rd = s_ff.cnt_start;
         OFS_CNT_TRIP: rd = s_ff.cnt_trip;
         OFS_CNT_BLOCK: rd = s_ff.cnt_block;
         OFS_IRQ_STAT: rd = {29'h0, s_ff.irq_stat};
         OFS_IRQ_EN: rd = {29'h0, s_ff.irq_en};
         OFS_REC_SEL: rd = {24'h0, s_ff.rcount, s_ff.rec_sel};
         OFS_REC_W0: rd = rr.stamp;
         OFS_REC_W1: rd = {23'h0, rr.group, rr.ftype, rr.code};
         OFS_REC_W2: rd = {rr.fault, rr.pre_trig};
         OFS_REC_W3: rd = {16'h0, rr.pre_fault};
         OFS_REC_W4: rd = {{11{rr.remain[20]}}, rr.remain};
         default: rd = 32'h0;
      endcase
      if (avs_i.read && !s_ff.ack) begin
         nxt_s.rdata = rd;
      end
      if (avs_i.write && s_ff.ack) begin
         unique case (avs_i.address)
            OFS_CTRL: nxt_s.enable = avs_i.writedata[0];
            OFS_PICKUP: nxt_s.pickup = avs_i.writedata[15:0];
            OFS_DELAY: nxt_s.delay = avs_i.writedata[19:0];
            OFS_RELEASE: nxt_s.release_t = avs_i.writedata[19:0];
            OFS_EV_FWD: nxt_s.ev_fwd = avs_i.writedata[5:0];
            OFS_IRQ_CLR: nxt_s.irq_stat = s_ff.irq_stat
                                          & ~avs_i.writedata[2:0];
            OFS_IRQ_EN: nxt_s.irq_en = avs_i.writedata[2:0];
            OFS_REC_SEL: nxt_s.rec_sel = avs_i.writedata[3:0];
            default: nxt_s.enable = s_ff.enable;
         endcase
      end
      // Set wins over a clear in the same cycle
      nxt_s.irq_stat = nxt_s.irq_stat
                       | {evs[EV_BLOCK_ON], evs[EV_TRIP_ON], evs[EV_START_ON]};
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_ff <= '0;
         s_ff.cond <= COND_NORMAL;
         s_ff.enable <= 1'b1;
         s_ff.pickup <= RST_PICKUP;
         s_ff.delay <= RST_DELAY;
         s_ff.release_t <= RST_RELEASE;
         s_ff.ev_fwd <= RST_EV_FWD;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign start_o = (s_ff.cond == COND_START) || (s_ff.cond == COND_TRIP);
   assign trip_o = (s_ff.cond == COND_TRIP);
   assign blocked_o = (s_ff.cond == COND_BLOCKED);
   assign event_o = s_ff.ev;
   assign irq_o = |(s_ff.irq_stat & s_ff.irq_en);
   assign avs_readdata_o = s_ff.rdata;
   assign avs_waitrequest_o = (avs_i.read || avs_i.write) && !s_ff.ack;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_clean_pickup;
      tick && pickup_hit && !s_ff.blk2;
   endsequence
   sequence s_blocked_pickup;
      tick && pickup_hit && s_ff.blk2;
   endsequence

   a_cond_onehot: assert property ($onehot(s_ff.cond))
      else $error("condition not one-hot");
   a_start_rise: assert property (
      s_ff.cond == COND_NORMAL ##0 s_clean_pickup |=> start_o && !blocked_o)
      else $error("clean pick-up did not start");
   a_block_hold: assert property (
      s_ff.cond == COND_NORMAL ##0 s_blocked_pickup
      |=> blocked_o && !start_o && s_ff.timer <= $past(s_ff.timer))
      else $error("blocked pick-up was timed");
   a_block_clear: assert property (
      (tick && s_ff.cond == COND_START && s_ff.blk2)
      |=> !start_o && s_ff.rel == s_ff.release_t)
      else $error("block left start set");
   a_trip_delay: assert property (
      (s_ff.cond == COND_START) ##0 s_clean_pickup
      ##0 (s_ff.timer + 20'h1 >= s_ff.delay) |=> trip_o)
      else $error("trip not at delay");
   a_remain_val: assert property (
      $rose(trip_o) |-> remain == 21'h0)
      else $error("remaining time not zero at trip");
   a_trip_count: assert property (
      $rose(trip_o) |-> s_ff.cnt_trip == $past(s_ff.cnt_trip) + 32'h1)
      else $error("trip counter missed");
   a_record_only: assert property (
      (s_ff.wptr != $past(s_ff.wptr)) |-> $rose(start_o) || $rose(trip_o)
      || $rose(blocked_o))
      else $error("record written without assertion");
   a_event_stamp: assert property (
      event_o.valid |-> event_o.stamp == $past(s_ff.ev_ts))
      else $error("event stamp mismatch");
   a_bus_answer: assert property (
      (avs_i.read && !s_ff.ack) |=> !avs_waitrequest_o)
      else $error("bus answer late");
endmodule

// ---- core/jam_pkg.sv ----
// Purpose: Shared constants and types for the load jam stage supervisor
// Assumes: 125 MHz core clock, 5 ms program cycle
// Notes: Offsets are byte addresses on the register bus
package jam_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int PROG_CYCLE_NS = 5000000;
   localparam int PROG_CYCLES = PROG_CYCLE_NS / CLK_PERIOD_NS;
   localparam int PRE_TRIG_MS = 20;
   localparam int PRE_FAULT_MS = 200;
   localparam int PROG_CYCLE_MS = 5;
   localparam int PRE_TRIG_TICKS = PRE_TRIG_MS / PROG_CYCLE_MS;
   localparam int PRE_FAULT_TICKS = PRE_FAULT_MS / PROG_CYCLE_MS;
   localparam int HIST_N = PRE_FAULT_TICKS + 1;
   localparam int REC_N = 12;
   localparam int DIV_STEPS = 23;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PICKUP = 8'h04;
   localparam logic [7:0] OFS_DELAY = 8'h08;
   localparam logic [7:0] OFS_RELEASE = 8'h0c;
   localparam logic [7:0] OFS_EV_FWD = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_EXP_TIME = 8'h18;
   localparam logic [7:0] OFS_REMAIN = 8'h1c;
   localparam logic [7:0] OFS_CNT_START = 8'h20;
   localparam logic [7:0] OFS_CNT_TRIP = 8'h24;
   localparam logic [7:0] OFS_CNT_BLOCK = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
   localparam logic [7:0] OFS_IRQ_EN = 8'h34;
   localparam logic [7:0] OFS_REC_SEL = 8'h38;
   localparam logic [7:0] OFS_REC_W0 = 8'h40;
   localparam logic [7:0] OFS_REC_W1 = 8'h44;
   localparam logic [7:0] OFS_REC_W2 = 8'h48;
   localparam logic [7:0] OFS_REC_W3 = 8'h4c;
   localparam logic [7:0] OFS_REC_W4 = 8'h50;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_PICKUP = 16'h0258;
   localparam logic [19:0] RST_DELAY = 20'h00014;
   localparam logic [19:0] RST_RELEASE = 20'h00000;
   localparam logic [5:0] RST_EV_FWD = 6'h3f;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      COND_NORMAL = 4'h1,
      COND_START = 4'h2,
      COND_TRIP = 4'h4,
      COND_BLOCKED = 4'h8
   } cond_type;
   typedef enum logic [2:0] {
      EV_START_ON = 3'h0, EV_START_OFF = 3'h1,
      EV_TRIP_ON = 3'h2, EV_TRIP_OFF = 3'h3,
      EV_BLOCK_ON = 3'h4, EV_BLOCK_OFF = 3'h5
   } ev_code_type;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } avs_req_type;
   typedef struct packed {
      logic [15:0] l1;
      logic [15:0] l2;
      logic [15:0] l3;
   } phase_cur_type;
   typedef struct packed {
      logic valid;
      ev_code_type code;
      logic [31:0] stamp;
   } event_type;
   typedef struct packed {
      logic [31:0] stamp;
      ev_code_type code;
      logic [2:0] ftype;
      logic [15:0] pre_trig;
      logic [15:0] fault;
      logic [15:0] pre_fault;
      logic [20:0] remain;
      logic [2:0] group;
   } record_type;
endpackage

// ---- verif/jam_far_side.sv ----
// Purpose: Far side model: blocking matrix and event buffer
// Assumes: One clock, synchronous active high reset
// Notes: Event buffer only counts what arrives, one byte per code
`timescale 1ns/1ns
module jam_far_side
   import jam_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic block_req_i,
   input wire event_type event_i,
   output logic block_o,
   output logic [47:0] seen_o
);
   // ---------------------------------------------------------------
   // Blocking matrix and event buffer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         block_o <= 1'b0;
         seen_o <= '0;
      end else begin
         // Bench raises the request many ticks before the delay ends
         block_o <= block_req_i;
         if (event_i.valid) begin
            seen_o[int'(event_i.code)*8 +: 8] <=
               seen_o[int'(event_i.code)*8 +: 8] + 8'h01;
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the load jam stage supervisor
// Assumes: Short program cycle of 40 clocks in simulation
// Notes: Stage outputs are sampled on the falling edge; the bus task samples waitrequest and read data on the rising edge
`timescale 1ns/1ns
module tb_top import jam_pkg::*;;
   localparam int TICK = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   avs_req_type avs = '0;
   phase_cur_type cur = '0;
   logic blk_req = 1'b0;
   logic blk;
   logic [31:0] ts = 32'h0;
   logic [31:0] rdata, q, t0;
   logic wreq, start, trip, blocked, irq;
   event_type ev;
   logic [47:0] seen;
   int num_errors = 0;
   int comparisons = 0;
   always #4 clk = ~clk;
   always @(posedge clk) ts <= ts + 32'h1;
   load_jam_stage #(.TICK_CYCLES(TICK)) dut (.core_clk_i(clk),
      .sys_rst_i(rst), .avs_i(avs), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .cur_i(cur), .block_i(blk),
      .timestamp_i(ts), .setting_group_i(3'h2), .start_o(start),
      .trip_o(trip), .blocked_o(blocked), .event_o(ev), .irq_o(irq));
   jam_far_side far (.core_clk_i(clk), .sys_rst_i(rst),
      .block_req_i(blk_req), .event_i(ev), .block_o(blk), .seen_o(seen));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      logic done = 1'b0;
      @(posedge clk);
      avs <= '{read: !wr, write: wr, address: a, writedata: d};
      while (!done && n < 100) begin
         @(posedge clk);
         done = !wreq;
         n++;
      end
      r = rdata;
      avs <= '0;
      if (!done) begin
         fail("bus timeout");
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      chk(48'(q), 48'(e));
   endtask
   task automatic wait_out(input int k, input logic v);
      int n = 0;
      logic [2:0] o;
      @(negedge clk);
      o = {blocked, trip, start};
      while (o[k] !== v && n < 3000) begin
         @(negedge clk);
         o = {blocked, trip, start};
         n++;
      end
      if (o[k] !== v) begin
         fail("output wait timeout");
         give_verdict();
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic run_reset();
      rd_chk(OFS_PICKUP, 32'h258);
      rd_chk(OFS_DELAY, 32'h14);
      rd_chk(OFS_EV_FWD, 32'h3f);
      rd_chk(OFS_STATUS, 32'h1);
      rd_chk(8'hfc, 32'h0);
   endtask
   task automatic run_trip();
      wr(OFS_DELAY, 32'h3);
      wr(OFS_EV_FWD, 32'h2f);
      wr(OFS_IRQ_EN, 32'h1);
      rd_chk(OFS_EXP_TIME, 32'h3);
      // Highest phase is not the first one
      cur <= '{l1: 16'h012c, l2: 16'h04b0, l3: 16'h01f4};
      wait_out(0, 1'b1);
      t0 = ts;
      rd_chk(OFS_CNT_START, 32'h1);
      @(negedge clk);
      chk(48'(irq), 48'h1);
      wr(OFS_IRQ_CLR, 32'h1);
      @(negedge clk);
      chk(48'(irq), 48'h0);
      wait_out(1, 1'b1);
      chk(48'(ts - t0), 48'(3 * TICK));
      rd_chk(OFS_STATUS, 32'hc84);
      cur <= '0;
      wait_out(1, 1'b0);
      chk(48'(start), 48'h0);
      rd_chk(OFS_CNT_TRIP, 32'h1);
   endtask
   task automatic run_block();
      wr(OFS_DELAY, 32'h32);
      cur <= '{l1: 16'h0384, l2: 16'h0000, l3: 16'h0000};
      wait_out(0, 1'b1);
      bus(1'b0, OFS_REMAIN, 32'h0, q);
      chk(48'(q inside {[1:50]}), 48'h1);
      blk_req <= 1'b1;
      wait_out(2, 1'b1);
      t0 = ts;
      chk(48'({start, trip}), 48'h0);
      @(posedge clk);
      cur <= '0;
      blk_req <= 1'b0;
      wait_out(2, 1'b0);
      rd_chk(OFS_CNT_BLOCK, 32'h1);
      wr(OFS_REC_SEL, 32'h0);
      rd_chk(OFS_REC_SEL, 32'h40);
      bus(1'b0, OFS_REC_W1, 32'h0, q);
      chk(48'(q & 32'h1c7), 48'h84);
      rd_chk(OFS_REC_W0, t0 - 32'h1);
      bus(1'b0, OFS_REC_W2, 32'h0, q);
      chk(48'(q[31:16]), 48'h384);
      // Block already present when pick-up comes: no start, no timing
      blk_req <= 1'b1;
      repeat (4) @(posedge clk);
      cur <= '{l1: 16'h0384, l2: 16'h0000, l3: 16'h0000};
      wait_out(2, 1'b1);
      chk(48'({start, trip}), 48'h0);
      rd_chk(OFS_CNT_START, 32'h2);
      cur <= '0;
      blk_req <= 1'b0;
      wait_out(2, 1'b0);
      rd_chk(OFS_CNT_BLOCK, 32'h2);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      run_reset();
      run_trip();
      run_block();
      // Block on is filtered out, all other codes arrive
      @(negedge clk);
      chk(seen, 48'h02_00_01_01_02_02);
      give_verdict();
   end
endmodule
